//--- core/pbgpio_pin_cell.sv
// One port pin: chooses the driving source and registers drive and enable
`timescale 1ns/1ns
module pbgpio_pin_cell (
  input  wire logic hclk,      // System clock
  input  wire logic hresetn,   // Asynchronous reset, active low
  input  wire logic dir_bit,   // Direction bit, 1 is output
  input  wire logic data_bit,  // Latched output value
  input  wire logic alt_sel,   // Timer output owns the pin
  input  wire logic alt_val,   // Timer output level
  output logic      pin_out,   // Registered pin drive level
  output logic      pin_oe     // Registered pin output enable
);

  pbgpio_pkg::pbgpio_src_t src; // Current drive source

  // Timer output wins over the direction bit
  always_comb begin
    src = alt_sel ? pbgpio_pkg::PBGPIO_SRC_TIMER : pbgpio_pkg::PBGPIO_SRC_GPIO; // [R9]
  end

  // Drive level and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      case (src)
        pbgpio_pkg::PBGPIO_SRC_TIMER: begin // Timer drives regardless of direction
          pin_out <= alt_val; // [R9]
          pin_oe  <= 1'b1;    // [R9]
        end
        default: begin // General-purpose path
          pin_out <= data_bit;
          pin_oe  <= dir_bit; // [R1]
        end
      endcase
    end
  end

endmodule // pbgpio_pin_cell

//--- core/pbgpio_port_b.sv
// Port B general-purpose port with timer and converter pin sharing, AHB-Lite slave
`timescale 1ns/1ns
`include "pbgpio_map.svh"
// Operation
// [R1] Direction bit 1 drives pin, 0 inputs
// [R2] Direction register reads back all ones
// [R3] Direction clears on reset and hardware standby
// [R4] Software standby keeps direction and driven outputs
// [R5] Eight-bit read/write output data latch
// [R6] Read returns latch if output, pin otherwise
// [R7] Data clears on reset/hardware standby, kept otherwise
// [R8] Decode lower sixteen bits: 0xffd4, 0xffd6; the code matches them against haddr[17:2], the word index
// [R9] Selected timer output drives pin, ignores direction
// [R10] Pins 4/5 complementary outputs when enabled and combined
// [R11] Pin 3 compare B output selection
// [R12] Pin 3 feeds capture B when selected
// [R13] Pin 2 compare A output selection
// [R14] Pin 2 feeds capture A when selected
// [R15] Pin 7 trigger when enabled; pin 6 plain
module pbgpio_port_b #(
  parameter int WIDTH = 8                          // Number of port pins
) (
  input  wire logic             hclk,                   // System clock, 125 MHz
  input  wire logic             hresetn,                // Asynchronous reset, active low
  input  wire logic             hsel,                   // Slave select
  input  wire logic [31:0]      haddr,                  // Byte address
  input  wire logic [1:0]       htrans,                 // Transfer type
  input  wire logic             hwrite,                 // Write when high
  input  wire logic [2:0]       hsize,                  // Transfer size
  input  wire logic [31:0]      hwdata,                 // Write data
  input  wire logic             hready,                 // Bus ready
  output logic                  hreadyout,              // Slave ready
  output logic                  hresp,                  // Response, always OKAY
  output logic [31:0]           hrdata,                 // Read data
  input  wire logic             hw_standby,             // Hardware standby, clears registers
  input  wire logic             sw_standby,             // Software standby, state held
  input  wire logic             combination_mode_bit,   // Channels 3 and 4 combined
  input  wire logic             ch4_pwm_select,         // Channel 4 PWM mode
  input  wire logic             ch4_out_a_enable,       // Channel 4 output A enable
  input  wire logic             ch4_out_b_enable,       // Channel 4 output B enable
  input  wire logic             compl_out_a_enable,     // Complementary output A enable
  input  wire logic             compl_out_b_enable,     // Complementary output B enable
  input  wire logic [2:0]       ch4_a_io,               // Channel 4 A-field setting
  input  wire logic [2:0]       ch4_b_io,               // Channel 4 B-field setting
  input  wire logic             adc_trigger_enable,     // Converter external trigger enable
  input  wire logic             timer4_capcmp_a_out,    // Compare A level from timer
  input  wire logic             timer4_capcmp_b_out,    // Compare B level from timer
  input  wire logic             timer4_compl_out_a,     // Complementary waveform A
  input  wire logic             timer4_compl_out_b,     // Complementary waveform B
  output logic                  timer4_capcmp_a_in,     // Pin 2 level to capture A
  output logic                  timer4_capcmp_b_in,     // Pin 3 level to capture B
  output logic                  adc_external_trigger_n, // Pin 7 level to converter, active low
  input  wire logic [WIDTH-1:0] pin_in,                 // Pin levels
  output logic [WIDTH-1:0]      pin_out,                // Pin drive levels
  output logic [WIDTH-1:0]      pin_oe                  // Pin output enables
);

  // Register state
  logic [WIDTH-1:0]         port_b_direction_reg;  // Direction, write-only
  logic [WIDTH-1:0]         port_b_data_latch_reg; // Output data latch

  // Bus address-phase capture
  pbgpio_pkg::pbgpio_sel_t  wr_sel_reg;            // Register chosen by a pending write
  pbgpio_pkg::pbgpio_sel_t  addr_sel;              // Register chosen by the current address
  logic                     access_taken;          // Address phase accepted this cycle
  logic [WIDTH-1:0]         read_value;            // Read data for the current address
  logic [WIDTH-1:0]         port_read;             // Mixed latch and pin view

  // Timer selection
  logic                     sel_out_a;             // Compare A owns pin 2
  logic                     sel_out_b;             // Compare B owns pin 3
  logic                     sel_compl_a;           // Waveform A owns pin 4
  logic                     sel_compl_b;           // Waveform B owns pin 5
  logic                     sel_cap_a;             // Capture A listens on pin 2
  logic                     sel_cap_b;             // Capture B listens on pin 3
  logic [WIDTH-1:0]         alt_sel;               // Per-pin timer ownership
  logic [WIDTH-1:0]         alt_val;               // Per-pin timer level

  // Decode of the register index from the byte address
  function automatic pbgpio_pkg::pbgpio_sel_t decode_index(input logic [31:0] addr);
    logic [15:0] index;
    index = addr[17:2];
    if (index == `PBGPIO_DIR_INDEX) begin // [R8]
      decode_index = pbgpio_pkg::PBGPIO_SEL_DIR;
    end else if (index == `PBGPIO_DATA_INDEX) begin // [R8]
      decode_index = pbgpio_pkg::PBGPIO_SEL_DATA;
    end else begin
      decode_index = pbgpio_pkg::PBGPIO_SEL_NONE;
    end
  endfunction

  // Address phase is accepted on a selected, ready NONSEQ transfer of at most word size
  always_comb begin
    access_taken = hsel && hready && (htrans == `PBGPIO_HTRANS_NONSEQ) && (hsize <= 3'h2);
    addr_sel     = decode_index(haddr);
  end

  // Port view: latch for output pins, live pin level for input pins
  always_comb begin
    port_read = (port_b_direction_reg & port_b_data_latch_reg) | (~port_b_direction_reg & pin_in); // [R6]
  end

  // Read value for the addressed register
  always_comb begin
    case (addr_sel)
      pbgpio_pkg::PBGPIO_SEL_DIR: begin // Stored value is never shown
        read_value = `PBGPIO_DIR_READBACK; // [R2]
      end
      pbgpio_pkg::PBGPIO_SEL_DATA: begin // Mixed view of the port
        read_value = port_read; // [R6]
      end
      default: begin // Unmapped reads as zero
        read_value = '0;
      end
    endcase
  end

  // Zero-wait slave with a fixed OKAY response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= `PBGPIO_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `PBGPIO_HRESP_OKAY;
    end
  end

  // Read data registered at the address phase, stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (access_taken && !hwrite) begin // Read address phase
      hrdata <= {{(32-WIDTH){1'b0}}, read_value};
    end else if (hready) begin // Clear once the data phase ends
      hrdata <= '0;
    end
  end

  // Pending write target, held until the data phase completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sel_reg <= pbgpio_pkg::PBGPIO_SEL_NONE;
    end else if (hready) begin // New address phase or idle
      wr_sel_reg <= (access_taken && hwrite) ? addr_sel : pbgpio_pkg::PBGPIO_SEL_NONE;
    end
  end

  // Direction register; software standby blocks writes so state is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_b_direction_reg <= `PBGPIO_DIR_RESET; // [R3]
    end else if (hw_standby) begin // Hardware standby clears all direction bits to input; timer-owned pins still drive
      port_b_direction_reg <= `PBGPIO_DIR_RESET; // [R3]
    end else if (sw_standby) begin // Kept through software standby
      port_b_direction_reg <= port_b_direction_reg; // [R4]
    end else if (wr_sel_reg == pbgpio_pkg::PBGPIO_SEL_DIR) begin // Data phase write
      port_b_direction_reg <= hwdata[WIDTH-1:0]; // [R1]
    end
  end

  // Data latch; software standby blocks writes so state is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_b_data_latch_reg <= `PBGPIO_DATA_RESET; // [R7]
    end else if (hw_standby) begin // Hardware standby clears the latch
      port_b_data_latch_reg <= `PBGPIO_DATA_RESET; // [R7]
    end else if (sw_standby) begin // Kept through software standby
      port_b_data_latch_reg <= port_b_data_latch_reg; // [R7]
    end else if (wr_sel_reg == pbgpio_pkg::PBGPIO_SEL_DATA) begin // Data phase write
      port_b_data_latch_reg <= hwdata[WIDTH-1:0]; // [R5]
    end
  end

  // Timer control decode
  pbgpio_timer_sel u_timer_sel (
    .combination_mode_bit (combination_mode_bit),
    .ch4_pwm_select       (ch4_pwm_select),
    .ch4_out_a_enable     (ch4_out_a_enable),
    .ch4_out_b_enable     (ch4_out_b_enable),
    .compl_out_a_enable   (compl_out_a_enable),
    .compl_out_b_enable   (compl_out_b_enable),
    .ch4_a_io             (ch4_a_io),
    .ch4_b_io             (ch4_b_io),
    .sel_out_a            (sel_out_a),
    .sel_out_b            (sel_out_b),
    .sel_compl_a          (sel_compl_a),
    .sel_compl_b          (sel_compl_b),
    .sel_cap_a            (sel_cap_a),
    .sel_cap_b            (sel_cap_b)
  );

  // Per-pin timer ownership; pins 0, 1, 6 and 7 stay general-purpose
  always_comb begin
    alt_sel = '0; // [R15]
    alt_val = '0;
    alt_sel[`PBGPIO_PIN_CAP_A]   = sel_out_a;   // [R13]
    alt_val[`PBGPIO_PIN_CAP_A]   = timer4_capcmp_a_out;
    alt_sel[`PBGPIO_PIN_CAP_B]   = sel_out_b;   // [R11]
    alt_val[`PBGPIO_PIN_CAP_B]   = timer4_capcmp_b_out;
    alt_sel[`PBGPIO_PIN_COMPL_A] = sel_compl_a; // [R10]
    alt_val[`PBGPIO_PIN_COMPL_A] = timer4_compl_out_a;
    alt_sel[`PBGPIO_PIN_COMPL_B] = sel_compl_b; // [R10]
    alt_val[`PBGPIO_PIN_COMPL_B] = timer4_compl_out_b;
  end

  // Pin cells; outputs keep driving while registers hold in software standby
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    pbgpio_pin_cell u_cell (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .dir_bit  (port_b_direction_reg[i]),  // [R4]
      .data_bit (port_b_data_latch_reg[i]),
      .alt_sel  (alt_sel[i]),
      .alt_val  (alt_val[i]),
      .pin_out  (pin_out[i]),
      .pin_oe   (pin_oe[i])
    );
  end

  // Capture inputs pass the pin level when selected; the port stays readable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer4_capcmp_a_in <= 1'b0;
      timer4_capcmp_b_in <= 1'b0;
    end else begin
      timer4_capcmp_a_in <= sel_cap_a && pin_in[`PBGPIO_PIN_CAP_A]; // [R14]
      timer4_capcmp_b_in <= sel_cap_b && pin_in[`PBGPIO_PIN_CAP_B]; // [R12]
    end
  end

  // Converter trigger follows pin 7 when enabled, idle high otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_external_trigger_n <= 1'b1;
    end else if (adc_trigger_enable) begin // Direction bit plays no part
      adc_external_trigger_n <= pin_in[`PBGPIO_PIN_TRIGGER]; // [R15]
    end else begin
      adc_external_trigger_n <= 1'b1;
    end
  end

endmodule // pbgpio_port_b

//--- core/pbgpio_timer_sel.sv
// Decode of the timer control bits into per-pin selects
`timescale 1ns/1ns
`include "pbgpio_map.svh"
module pbgpio_timer_sel (
  input  wire logic       combination_mode_bit, // Channels 3 and 4 combined
  input  wire logic       ch4_pwm_select,       // Channel 4 PWM mode
  input  wire logic       ch4_out_a_enable,     // Channel 4 output A enable
  input  wire logic       ch4_out_b_enable,     // Channel 4 output B enable
  input  wire logic       compl_out_a_enable,   // Complementary output A enable
  input  wire logic       compl_out_b_enable,   // Complementary output B enable
  input  wire logic [2:0] ch4_a_io,             // Channel 4 A-field setting
  input  wire logic [2:0] ch4_b_io,             // Channel 4 B-field setting
  output logic            sel_out_a,            // Compare A drives pin 2
  output logic            sel_out_b,            // Compare B drives pin 3
  output logic            sel_compl_a,          // Waveform A drives pin 4
  output logic            sel_compl_b,          // Waveform B drives pin 5
  output logic            sel_cap_a,            // Pin 2 feeds capture A
  output logic            sel_cap_b             // Pin 3 feeds capture B
);

  // A field asks for a compare output: top bit clear and a nonzero low part
  function automatic logic field_is_output(input logic [2:0] io);
    field_is_output = !io[`PBGPIO_IO_TOP_BIT] && (io[`PBGPIO_IO_MID_BIT] || io[`PBGPIO_IO_LOW_BIT]);
  endfunction

  // A field asks for input capture, valid only outside combined and PWM modes
  function automatic logic field_is_capture(input logic [2:0] io, input logic cmb, input logic pwm);
    field_is_capture = !cmb && !pwm && io[`PBGPIO_IO_TOP_BIT];
  endfunction

  // Output and capture selection
  always_comb begin
    sel_compl_a = compl_out_a_enable && combination_mode_bit; // [R10]
    sel_compl_b = compl_out_b_enable && combination_mode_bit; // [R10]
    sel_out_b   = ch4_out_b_enable && (combination_mode_bit || field_is_output(ch4_b_io)); // [R11]
    sel_out_a   = ch4_out_a_enable && (combination_mode_bit || ch4_pwm_select ||
                  field_is_output(ch4_a_io)); // [R13]
    sel_cap_b   = field_is_capture(ch4_b_io, combination_mode_bit, ch4_pwm_select); // [R12]
    sel_cap_a   = field_is_capture(ch4_a_io, combination_mode_bit, ch4_pwm_select); // [R14]
  end

endmodule // pbgpio_timer_sel

//--- pkg/pbgpio_map.svh
// Register offsets, reset values and field positions of the port B block
`ifndef PBGPIO_MAP_SVH
`define PBGPIO_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define PBGPIO_DIR_INDEX      16'hffd4
`define PBGPIO_DATA_INDEX     16'hffd6

// Reset values
`define PBGPIO_DIR_RESET      8'h00
`define PBGPIO_DATA_RESET     8'h00

// Value returned by a read of the write-only direction register
`define PBGPIO_DIR_READBACK   8'hff

// Pin positions of the shared functions
`define PBGPIO_PIN_CAP_A      2
`define PBGPIO_PIN_CAP_B      3
`define PBGPIO_PIN_COMPL_A    4
`define PBGPIO_PIN_COMPL_B    5
`define PBGPIO_PIN_TRIGGER    7

// Positions inside the channel 4 capture/compare field
`define PBGPIO_IO_TOP_BIT     2
`define PBGPIO_IO_MID_BIT     1
`define PBGPIO_IO_LOW_BIT     0

// AHB encodings
`define PBGPIO_HTRANS_NONSEQ  2'b10
`define PBGPIO_HRESP_OKAY     1'b0

`endif

//--- pkg/pbgpio_pkg.sv
// Types shared by the port B block
package pbgpio_pkg;

  // Source that drives a pin
  typedef enum logic [1:0] {
    PBGPIO_SRC_GPIO,
    PBGPIO_SRC_TIMER
  } pbgpio_src_t;

  // Register selected by a bus access
  typedef enum logic [1:0] {
    PBGPIO_SEL_NONE,
    PBGPIO_SEL_DIR,
    PBGPIO_SEL_DATA
  } pbgpio_sel_t;

endpackage

//--- test/pbgpio_board.sv
// Board-side model of the port B pins
`timescale 1ns/1ns
module pbgpio_board (
  pin_out,  // Levels the port drives
  pin_oe,   // Port drive enables
  ext,      // Levels the board drives
  pin_in    // Resolved pin levels
);
  input  wire logic [7:0] pin_out;
  input  wire logic [7:0] pin_oe;
  input  wire logic [7:0] ext;
  output logic      [7:0] pin_in;
  // A driven pin shows the port level, an undriven one the board level
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // pbgpio_board

//--- test/pbgpio_port_b_bench.sv
// Self-checking bench for the port B block
`timescale 1ns/1ns
`include "pbgpio_map.svh"
module pbgpio_port_b_bench;
  localparam logic [31:0] DIR_A  = {14'h0000, `PBGPIO_DIR_INDEX, 2'b00};  // Direction byte address
  localparam logic [31:0] DATA_A = {14'h0000, `PBGPIO_DATA_INDEX, 2'b00}; // Data byte address
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hws, sws, ready_s; // Bus and standby
  logic        cmb, pwm, ena, enb, exa, exb, trg, ta, tb, xa, xb, cia, cib, trn;  // Timer side
  logic [1:0]  htrans;                                                      // Transfer type
  logic [2:0]  hsize, aio, bio;                                             // Size and fields
  logic [31:0] haddr, hwdata, hrdata, rdata_s, rd, lfsr_reg;                // Bus words, random state
  logic [7:0]  ext, pin_in, pin_out, pin_oe, own_m, oe_m, out_m, pin_m;     // Pins and predictions
  int          dir_m, data_m, bad_count, n_tests;                           // Model and counters
  pbgpio_port_b #(.WIDTH(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hw_standby(hws), .sw_standby(sws), .combination_mode_bit(cmb), .ch4_pwm_select(pwm),
    .ch4_out_a_enable(ena), .ch4_out_b_enable(enb), .compl_out_a_enable(exa), .compl_out_b_enable(exb),
    .ch4_a_io(aio), .ch4_b_io(bio), .adc_trigger_enable(trg), .timer4_capcmp_a_out(ta),
    .timer4_capcmp_b_out(tb), .timer4_compl_out_a(xa), .timer4_compl_out_b(xb), .timer4_capcmp_a_in(cia),
    .timer4_capcmp_b_in(cib), .adc_external_trigger_n(trn), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pbgpio_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  // Clock at 125 MHz
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Bus answers as they stand just before each rising edge
  always @(negedge hclk) begin
    ready_s = hreadyout;
    rdata_s = hrdata;
  end
  // Next random word
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Count and report one comparison
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Step edges until ready is seen high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (ready_s !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        results();
      end
      @(posedge hclk);
    end
  endtask
  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    htrans <= `PBGPIO_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rdv = rdata_s;
  endtask
  // Predicted drive and pin level for the present settings
  task automatic predict();
    own_m = {2'b00, cmb & exb, cmb & exa, enb & (cmb | (!bio[2] & (|bio[1:0]))),
             ena & (cmb | pwm | (!aio[2] & (|aio[1:0]))), 2'b00};
    oe_m  = own_m | 8'(dir_m);
    out_m = (own_m & {2'b00, xb, xa, tb, ta, 2'b00}) | (~own_m & 8'(data_m));
    pin_m = (oe_m & out_m) | (~oe_m & ext);
  endtask
  // Settle pins, then compare drive and the port read
  task automatic pins_and_read(input string tag);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    predict();
    check({tag, " oe"}, 32'(pin_oe), 32'(oe_m));
    check({tag, " out"}, 32'(pin_out), 32'(out_m));
    check({tag, " capture a"}, 32'(cia), 32'(!cmb & !pwm & aio[2] & pin_m[2]));
    check({tag, " capture b"}, 32'(cib), 32'(!cmb & !pwm & bio[2] & pin_m[3]));
    check({tag, " trigger"}, 32'(trn), 32'(trg ? pin_m[7] : 1'b1));
    @(posedge hclk);
    bus(1'b0, DATA_A, 32'h0, rd);
    check({tag, " port read"}, rd, {24'h0, (8'(dir_m) & 8'(data_m)) | (~8'(dir_m) & pin_m)});
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    results();
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, hws, sws, cmb, pwm, ena, enb, exa, exb, trg, ta, tb, xa, xb} = 16'h4000;
    {htrans, aio, bio, haddr, hwdata} = '0;
    hsize = 3'b010;
    ext = 8'h5a;
    lfsr_reg = 32'hff1599a3;
    {dir_m, data_m, bad_count, n_tests} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, DIR_A, 32'h0, rd);
    check("direction read", rd, 32'h000000ff);
    pins_and_read("reset");
    for (int i = 0; i < 8; i++) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      ext <= lfsr_reg[15:8];
      bus(1'b1, DIR_A, lfsr_reg, rd);
      dir_m = lfsr_reg[7:0];
      lfsr_reg = lfsr_step(lfsr_reg);
      bus(1'b1, DATA_A | {lfsr_reg[31:18], 18'h0}, lfsr_reg, rd);
      data_m = lfsr_reg[7:0];
      pins_and_read("gpio");
    end
    bus(1'b1, DIR_A + 32'h4, 32'ha5, rd);
    bus(1'b0, DIR_A + 32'h4, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    pins_and_read("after unmapped");
    sws <= 1'b1;
    bus(1'b1, DATA_A, ~data_m, rd);
    bus(1'b1, DIR_A, ~dir_m, rd);
    pins_and_read("software standby");
    sws <= 1'b0;
    hws <= 1'b1;
    repeat (2) @(posedge hclk);
    hws <= 1'b0;
    {dir_m, data_m} = '0;
    pins_and_read("hardware standby");
    for (int i = 0; i < 16; i++) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      {cmb, pwm, ena, enb, exa, exb, trg, ta, tb, xa, xb} <= lfsr_reg[10:0];
      aio <= 3'(i);
      bio <= 3'(i >> 1);
      ext <= lfsr_reg[18:11];
      bus(1'b1, DIR_A, {24'h0, lfsr_reg[31:24]}, rd);
      dir_m = lfsr_reg[31:24];
      bus(1'b1, DATA_A, {24'h0, lfsr_reg[26:19]}, rd);
      data_m = lfsr_reg[26:19];
      pins_and_read("timer");
    end
    results();
  end
endmodule // pbgpio_port_b_bench

//--- test/pbgpio_port_b_chk.sv
// Concurrent checks on the port B block ports
`timescale 1ns/1ns
`include "pbgpio_map.svh"
module pbgpio_port_b_chk #(
  parameter int WIDTH = 8                           // Number of port pins
) (
  input wire logic             hclk,                   // Clock
  input wire logic             hresetn,                // Reset, active low
  input wire logic             hsel,                   // Select
  input wire logic [31:0]      haddr,                  // Address
  input wire logic [1:0]       htrans,                 // Transfer type
  input wire logic             hwrite,                 // Write
  input wire logic [2:0]       hsize,                  // Size
  input wire logic             hready,                 // Bus ready
  input wire logic             hreadyout,              // Slave ready
  input wire logic             hresp,                  // Response
  input wire logic [31:0]      hrdata,                 // Read data
  input wire logic             hw_standby,             // Hardware standby
  input wire logic             combination_mode_bit,   // Combined mode
  input wire logic             ch4_pwm_select,         // PWM mode
  input wire logic             ch4_out_a_enable,       // Output A enable
  input wire logic             ch4_out_b_enable,       // Output B enable
  input wire logic             compl_out_a_enable,     // Waveform A enable
  input wire logic [2:0]       ch4_a_io,               // A-field
  input wire logic [2:0]       ch4_b_io,               // B-field
  input wire logic             adc_trigger_enable,     // Trigger enable
  input wire logic             timer4_capcmp_a_out,    // Compare A level
  input wire logic             timer4_capcmp_b_out,    // Compare B level
  input wire logic             timer4_compl_out_a,     // Waveform A level
  input wire logic             timer4_capcmp_a_in,     // Capture A feed
  input wire logic             timer4_capcmp_b_in,     // Capture B feed
  input wire logic             adc_external_trigger_n, // Trigger feed
  input wire logic [WIDTH-1:0] pin_in,                 // Pin levels
  input wire logic [WIDTH-1:0] pin_out,                // Pin drive
  input wire logic [WIDTH-1:0] pin_oe                  // Pin enables
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic warm;                                         // Past values are from after reset
  wire  own_a = ch4_out_a_enable & (combination_mode_bit | ch4_pwm_select | (!ch4_a_io[2] & (|ch4_a_io[1:0])));
  wire  own_b = ch4_out_b_enable & (combination_mode_bit | (!ch4_b_io[2] & (|ch4_b_io[1:0])));
  wire  rd_dir = hsel && hready && htrans == `PBGPIO_HTRANS_NONSEQ && !hwrite && hsize <= 3'h2;
  // Marks the second edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm <= 1'b0;
    end else begin
      warm <= 1'b1;
    end
  end
  bus_okay_a: assert property (hreadyout && hresp == 1'b0) else $error("bus answer not ready or not okay");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000) else $error("read data upper bits set");
  dir_read_a: assert property (rd_dir && haddr[17:2] == `PBGPIO_DIR_INDEX |=> hrdata == 32'h000000ff)
    else $error("direction read not all ones");
  trig_follow_a: assert property (warm |-> adc_external_trigger_n ==
    ($past(adc_trigger_enable) ? $past(pin_in[7]) : 1'b1)) else $error("trigger feed wrong");
  cap_a_feed_a: assert property (warm |-> timer4_capcmp_a_in == (($past(ch4_a_io[2]) &&
    !$past(combination_mode_bit) && !$past(ch4_pwm_select)) ? $past(pin_in[2]) : 1'b0)) else $error("capture A wrong");
  cap_b_feed_a: assert property (warm |-> timer4_capcmp_b_in == (($past(ch4_b_io[2]) &&
    !$past(combination_mode_bit) && !$past(ch4_pwm_select)) ? $past(pin_in[3]) : 1'b0)) else $error("capture B wrong");
  out_a_own_a: assert property (warm && $past(own_a) |-> pin_oe[2] &&
    pin_out[2] == $past(timer4_capcmp_a_out)) else $error("compare A not on pin 2");
  out_b_own_a: assert property (warm && $past(own_b) |-> pin_oe[3] &&
    pin_out[3] == $past(timer4_capcmp_b_out)) else $error("compare B not on pin 3");
  compl_own_a: assert property (warm && $past(combination_mode_bit && compl_out_a_enable) |->
    pin_oe[4] && pin_out[4] == $past(timer4_compl_out_a)) else $error("waveform A not on pin 4");
  hw_clear_a: assert property (hw_standby |-> ##2 (pin_oe & 8'hc3) == 8'h00) else $error("pin left driven");
  cover property (own_a && own_b);
  cover property (combination_mode_bit && compl_out_a_enable);
  cover property (hw_standby);
endmodule // pbgpio_port_b_chk

bind pbgpio_port_b pbgpio_port_b_chk #(.WIDTH(WIDTH)) chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .hw_standby(hw_standby), .combination_mode_bit(combination_mode_bit),
  .ch4_pwm_select(ch4_pwm_select), .ch4_out_a_enable(ch4_out_a_enable), .ch4_out_b_enable(ch4_out_b_enable),
  .compl_out_a_enable(compl_out_a_enable), .ch4_a_io(ch4_a_io), .ch4_b_io(ch4_b_io),
  .adc_trigger_enable(adc_trigger_enable), .timer4_capcmp_a_out(timer4_capcmp_a_out),
  .timer4_capcmp_b_out(timer4_capcmp_b_out), .timer4_compl_out_a(timer4_compl_out_a),
  .timer4_capcmp_a_in(timer4_capcmp_a_in), .timer4_capcmp_b_in(timer4_capcmp_b_in),
  .adc_external_trigger_n(adc_external_trigger_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
